// ==== bwd_board_watchdog.sv ====
// bwd_board_watchdog: board watchdog armed and disarmed by host i/o reads
// assumes ioRead is a one-cycle strobe synchronous to clk_sys with ioAddr valid;
// jumper settings are static straps, sampled every cycle
`timescale 1ns/1ps
`default_nettype none
module bwd_board_watchdog
  import bwd_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  ioRead,
  input  wire logic [BWD_ADDR_W-1:0] ioAddr,
  input  wire logic [3:0]            period_select_setting,
  input  wire logic [1:0]            action_select_setting,
  output var  logic                  sysReset,
  output var  logic                  nmi,
  output var  logic                  armed,
  output var  logic                  portHit
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    bwd_state_t           fsm;
    logic [BWD_CNT_W-1:0] cnt;
    logic [BWD_PLS_W-1:0] pls;
    logic                 rst;
    logic                 nmi;
    logic                 hit;
    logic                 arm;
  } bwd_reg_t;

  bwd_reg_t st;
  bwd_reg_t next_st;
  logic     tick;
  logic     armRd;
  logic     disRd;
  logic     loadCnt;
  bwd_act_t act;
  logic     actOn;

  // period select to milliseconds; unlisted codes fall back to the shortest
  function automatic logic [BWD_CNT_W-1:0] periodMs(input logic [3:0] sel);
    logic [BWD_CNT_W-1:0] ms;
    ms = BWD_CNT_W'(BWD_T1_S * 1000);
    case (sel)
      BWD_SEL_1S:   ms = BWD_CNT_W'(BWD_T1_S * 1000);
      BWD_SEL_2S:   ms = BWD_CNT_W'(BWD_T2_S * 1000);
      BWD_SEL_10S:  ms = BWD_CNT_W'(BWD_T10_S * 1000);
      BWD_SEL_20S:  ms = BWD_CNT_W'(BWD_T20_S * 1000);
      BWD_SEL_110S: ms = BWD_CNT_W'(BWD_T110_S * 1000);
      BWD_SEL_220S: ms = BWD_CNT_W'(BWD_T220_S * 1000);
      default:      ms = BWD_CNT_W'(BWD_T1_S * 1000);
    endcase
    return ms;
  endfunction : periodMs

  // ***********************************************************
  // port decode
  // ***********************************************************
  // control port decode
  assign armRd = ioRead && (ioAddr == BWD_PORT_ARM);
  assign disRd = ioRead && (ioAddr == BWD_PORT_DISARM);
  assign act   = bwd_act_t'(action_select_setting);
  // the unused jumper code counts as open, so only the two real positions arm
  assign actOn = (act == BWD_ACT_NMI) || (act == BWD_ACT_RESET);

  // restart the millisecond phase on every reload so each period is full
  assign loadCnt = armRd && actOn;

  bwd_tick_div u_div (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .restart (loadCnt),
    .tick    (tick)
  );

  // ***********************************************************
  // watchdog sequencing
  // ***********************************************************
  always_comb
  begin
    next_st     = st;
    next_st.hit = armRd || disRd;
    next_st.rst = 1'b0;
    next_st.nmi = 1'b0;
    case (st.fsm)
      BWD_ST_IDLE:
      begin
        if (loadCnt)
        begin
          next_st.fsm = BWD_ST_ARMED;
          next_st.cnt = periodMs(period_select_setting);
        end
      end
      BWD_ST_ARMED:
      begin
        if (disRd || !actOn)
        begin
          next_st.fsm = BWD_ST_IDLE;
          next_st.cnt = '0;
        end
        else if (armRd)
        begin
          next_st.cnt = periodMs(period_select_setting);
        end
        else if (tick)
        begin
          if (st.cnt <= BWD_CNT_W'(1))
          begin
            next_st.fsm = BWD_ST_FIRE;
            next_st.cnt = '0;
            next_st.pls = BWD_PLS_W'(BWD_PULSE_CYC - 1);
          end
          else
          begin
            next_st.cnt = st.cnt - 1'b1;
          end
        end
      end
      BWD_ST_FIRE:
      begin
        next_st.rst = (act == BWD_ACT_RESET);
        next_st.nmi = (act == BWD_ACT_NMI);
        // re-arm during pulse
        // an arm read is never lost: it restarts counting and cuts the pulse short
        if (loadCnt)
        begin
          next_st.fsm = BWD_ST_ARMED;
          next_st.cnt = periodMs(period_select_setting);
          next_st.rst = 1'b0;
          next_st.nmi = 1'b0;
        end
        else if (st.pls == '0)
        begin
          // one-shot: watchdog stays disarmed until software arms it again
          next_st.fsm = BWD_ST_IDLE;
          next_st.rst = 1'b0;
          next_st.nmi = 1'b0;
        end
        else
        begin
          next_st.pls = st.pls - 1'b1;
        end
      end
      default:
      begin
        next_st.fsm = BWD_ST_IDLE;
      end
    endcase
    // armed follows the counting state only, so it drops when the timeout fires
    next_st.arm = (next_st.fsm == BWD_ST_ARMED);
  end

  // one register stage for the whole state
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign sysReset = st.rst;
  assign nmi      = st.nmi;
  assign armed    = st.arm;
  assign portHit  = st.hit;

endmodule : bwd_board_watchdog
`default_nettype wire

// ==== bwd_board_watchdog_bench.sv ====
// bwd_board_watchdog_bench: self-checking bench for the board watchdog
// assumes the host model makes reads; full timeouts are too long to run here
`timescale 1ns/1ps
`default_nettype none
module bwd_board_watchdog_bench
  import bwd_pkg::*;
;
  logic                  clk_sys = 1'b0;
  logic                  nrst    = 1'b0;
  logic [3:0]            perSel  = BWD_SEL_1S;
  logic [1:0]            actSel  = BWD_ACT_RESET;
  logic                  ioRead, sysReset, nmi, armed, portHit;
  logic [BWD_ADDR_W-1:0] ioAddr;
  int                    n_errors = 0;
  int                    checks   = 0;
  int                    cyc      = 0;
  logic [3:0]            codes[6] = '{BWD_SEL_1S, BWD_SEL_2S, BWD_SEL_10S, BWD_SEL_20S, BWD_SEL_110S, BWD_SEL_220S};
  int                    perMs[6] = '{BWD_T1_S * 1000, BWD_T2_S * 1000, BWD_T10_S * 1000, BWD_T20_S * 1000,
                                      BWD_T110_S * 1000, BWD_T220_S * 1000};
  always #10 clk_sys = ~clk_sys;
  bwd_host i_host (.clk_sys(clk_sys), .ioRead(ioRead), .ioAddr(ioAddr));
  bwd_board_watchdog i_dut (.clk_sys(clk_sys), .nrst(nrst), .ioRead(ioRead), .ioAddr(ioAddr),
    .period_select_setting(perSel), .action_select_setting(actSel), .sysReset(sysReset), .nmi(nmi),
    .armed(armed), .portHit(portHit));
  // ************************************
  // scenarios
  // ************************************
  task automatic chk(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask : chk
  // wide compare on logic so an unknown never passes
  task automatic chkv(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
    end
  endtask : chkv
  task automatic t_arm_disarm;
    i_host.rd(BWD_PORT_ARM);
    chk("armed", 1'b1, armed);
    chk("portHit", 1'b1, portHit);
    i_host.rd(BWD_PORT_DISARM);
    chk("armed", 1'b0, armed);
    chk("portHit", 1'b1, portHit);
    i_host.rd(BWD_PORT_ALIAS);
    chk("portHit", 1'b0, portHit);
  endtask : t_arm_disarm
  task automatic t_actions;
    for (int a = 0; a < 4; a++)
    begin
      actSel = a[1:0];
      i_host.rd(BWD_PORT_ARM);
      chk("armed", (a == 1 || a == 2), armed);
      @(negedge clk_sys);
      actSel = BWD_ACT_OFF;
      repeat (3) @(negedge clk_sys);
      chk("armed", 1'b0, armed);
    end
  endtask : t_actions
  // each code arms, is retriggered and stays quiet well inside its period
  task automatic t_periods;
    actSel = BWD_ACT_NMI;
    foreach (codes[i])
    begin
      perSel = codes[i];
      i_host.rd(BWD_PORT_ARM);
      chkv("loaded period", 32'(perMs[i]), 32'(i_dut.st.cnt));
      repeat (300) @(negedge clk_sys);
      i_host.rd(BWD_PORT_ARM);
      chk("armed", 1'b1, armed);
      chk("nmi", 1'b0, nmi);
      i_host.rd(BWD_PORT_DISARM);
      repeat (50) @(negedge clk_sys);
      chk("sysReset", 1'b0, sysReset);
    end
  endtask : t_periods
  // one millisecond tick counts the period down; a retrigger reloads it in full
  task automatic t_retrig;
    actSel = BWD_ACT_RESET;
    perSel = BWD_SEL_1S;
    i_host.rd(BWD_PORT_ARM);
    repeat (50010) @(negedge clk_sys);
    chkv("count", 32'(BWD_T1_S * 1000 - 1), 32'(i_dut.st.cnt));
    chk("sysReset", 1'b0, sysReset);
    i_host.rd(BWD_PORT_ARM);
    chkv("count", 32'(BWD_T1_S * 1000), 32'(i_dut.st.cnt));
    chk("armed", 1'b1, armed);
    i_host.rd(BWD_PORT_DISARM);
    chk("armed", 1'b0, armed);
  endtask : t_retrig
  task automatic end_sim;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // hang guard above the roughly 52k cycles the scenarios need
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    t_arm_disarm();
    t_actions();
    t_periods();
    t_retrig();
    end_sim();
  end
endmodule : bwd_board_watchdog_bench
`default_nettype wire

// ==== bwd_board_watchdog_chk.sv ====
// bwd_board_watchdog_chk: port assertions for the board watchdog
// assumes static jumpers and one-cycle read strobes
`timescale 1ns/1ps
`default_nettype none
module bwd_board_watchdog_chk
  import bwd_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  ioRead,
  input  wire logic [BWD_ADDR_W-1:0] ioAddr,
  input  wire logic [3:0]            period_select_setting,
  input  wire logic [1:0]            action_select_setting,
  input  wire logic                  sysReset,
  input  wire logic                  nmi,
  input  wire logic                  armed,
  input  wire logic                  portHit
);
  // ************************************
  // sequences and properties
  // ************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic actOn;
  // open and the unused code both mean disabled
  assign actOn = (action_select_setting == BWD_ACT_NMI) || (action_select_setting == BWD_ACT_RESET);
  sequence s_arm;
    ioRead && ioAddr == BWD_PORT_ARM;
  endsequence
  sequence s_dis;
    ioRead && ioAddr == BWD_PORT_DISARM;
  endsequence
  a_arm_sets: assert property (s_arm ##0 actOn |=> armed) else $error("armed not set");
  a_arm_cause: assert property ($rose(armed) |-> $past(ioRead) && $past(ioAddr) == BWD_PORT_ARM)
    else $error("armed rose without arm read");
  a_disarm_clr: assert property (s_dis |=> !armed) else $error("armed after disarm");
  a_hit_follow: assert property (ioRead && (ioAddr == BWD_PORT_ARM || ioAddr == BWD_PORT_DISARM) |=> portHit)
    else $error("no port hit");
  a_hit_cause: assert property (portHit |-> $past(ioRead) &&
    ($past(ioAddr) == BWD_PORT_ARM || $past(ioAddr) == BWD_PORT_DISARM))
    else $error("stray port hit");
  a_open_off: assert property (!actOn ##1 !actOn |-> !armed) else $error("armed while open");
  a_rst_route: assert property (sysReset |-> action_select_setting == BWD_ACT_RESET)
    else $error("reset not selected");
  a_nmi_route: assert property (nmi |-> action_select_setting == BWD_ACT_NMI) else $error("nmi not selected");
  a_fire_armed: assert property ($rose(sysReset) || $rose(nmi) |-> $past(armed, 2))
    else $error("fired while idle");
endmodule : bwd_board_watchdog_chk
bind bwd_board_watchdog bwd_board_watchdog_chk i_chk (.clk_sys(clk_sys), .nrst(nrst), .ioRead(ioRead),
  .ioAddr(ioAddr), .period_select_setting(period_select_setting),
  .action_select_setting(action_select_setting), .sysReset(sysReset), .nmi(nmi), .armed(armed), .portHit(portHit));
`default_nettype wire

// ==== bwd_host.sv ====
// bwd_host: host cpu model issuing single i/o port reads
// assumes one clock; strobes change on falling edges only
`timescale 1ns/1ps
`default_nettype none
module bwd_host
  import bwd_pkg::*;
(
  input  wire logic                  clk_sys,
  output var  logic                  ioRead,
  output var  logic [BWD_ADDR_W-1:0] ioAddr
);
  initial
  begin
    ioRead = 1'b0;
    ioAddr = 16'hFFFF;
  end
  // retrigger by rereading
  // the address is inverted after the strobe so a stale value never decodes
  task automatic rd(input logic [BWD_ADDR_W-1:0] a);
    @(negedge clk_sys);
    ioRead = 1'b1;
    ioAddr = a;
    @(negedge clk_sys);
    ioRead = 1'b0;
    ioAddr = ~a;
  endtask : rd
endmodule : bwd_host
`default_nettype wire

// ==== bwd_pkg.sv ====
// bwd_pkg: constants and types for the board watchdog timer
// assumes a 50 MHz system clock and host i/o reads decoded to a port address
//
// Summary of operation
// - a host i/o read of port 443h arms the watchdog and starts counting
// - a host i/o read of port 843h disarms the watchdog, no timeout action
// - the control logic answers host reads at the watchdog control ports
// - an armed watchdog that times out raises system reset or nmi as selected
// - timeout period is one of 1, 2, 10, 20, 110 or 220 seconds
// - period select 0010=1s 0011=2s 0100=10s 0101=20s 1000=110s 1001=220s
// - action select: reset position, nmi position, or open disables the watchdog
package bwd_pkg;

  // ***********************************************************
  // host i/o port addresses
  // ***********************************************************
  localparam logic [15:0] BWD_PORT_ARM    = 16'h0443;
  localparam logic [15:0] BWD_PORT_DISARM = 16'h0843;
  localparam logic [15:0] BWD_PORT_ALIAS  = 16'h0043;
  localparam int          BWD_ADDR_W      = 16;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int          BWD_CLK_HZ      = 50_000_000;
  localparam int          BWD_TICK_MS     = 1;
  localparam int          BWD_TICK_CYC    = BWD_CLK_HZ / 1000 * BWD_TICK_MS;
  localparam int          BWD_DIV_W       = 16;
  localparam int          BWD_CNT_W       = 18;
  // timeout action pulse length, in microseconds and in system clocks
  localparam int          BWD_PULSE_US    = 10;
  localparam int          BWD_PULSE_CYC   = BWD_CLK_HZ / 1_000_000 * BWD_PULSE_US;
  localparam int          BWD_PLS_W       = 10;

  // periods in seconds
  localparam int          BWD_T1_S        = 1;
  localparam int          BWD_T2_S        = 2;
  localparam int          BWD_T10_S       = 10;
  localparam int          BWD_T20_S       = 20;
  localparam int          BWD_T110_S      = 110;
  localparam int          BWD_T220_S      = 220;

  // ***********************************************************
  // period select codes, bit3 = pins 1-2 ... bit0 = pins 7-8, on = 1
  // ***********************************************************
  localparam logic [3:0]  BWD_SEL_1S      = 4'h2;
  localparam logic [3:0]  BWD_SEL_2S      = 4'h3;
  localparam logic [3:0]  BWD_SEL_10S     = 4'h4;
  localparam logic [3:0]  BWD_SEL_20S     = 4'h5;
  localparam logic [3:0]  BWD_SEL_110S    = 4'h8;
  localparam logic [3:0]  BWD_SEL_220S    = 4'h9;

  // action select setting
  typedef enum logic [1:0] {
    BWD_ACT_OFF   = 2'h0,
    BWD_ACT_NMI   = 2'h1,
    BWD_ACT_RESET = 2'h2
  } bwd_act_t;

  // watchdog state, gray along idle -> armed -> fired
  typedef enum logic [1:0] {
    BWD_ST_IDLE  = 2'h0,
    BWD_ST_ARMED = 2'h1,
    BWD_ST_FIRE  = 2'h3
  } bwd_state_t;

endpackage : bwd_pkg

// ==== bwd_tick_div.sv ====
// bwd_tick_div: divides the system clock into a 1 ms enable pulse
// assumes a single free-running clock; restart aligns the tick phase
`timescale 1ns/1ps
`default_nettype none
module bwd_tick_div
  import bwd_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic restart,
  output var  logic tick
);

  typedef struct packed {
    logic [BWD_DIV_W-1:0] cnt;
    logic                 tick;
  } bwd_div_t;

  bwd_div_t st;
  bwd_div_t next_st;

  // count down one millisecond, pulse at wrap
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (restart)
    begin
      next_st.cnt = BWD_DIV_W'(BWD_TICK_CYC - 1);
    end
    else if (st.cnt == '0)
    begin
      next_st.cnt  = BWD_DIV_W'(BWD_TICK_CYC - 1);
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule : bwd_tick_div
`default_nettype wire
